// file: hw/clk_ctrl_pkg.sv
// Constants shared by the clock generator control block
`default_nettype none
package clk_ctrl_pkg;
  // ------------------------------------------------------------------
  // Widths and structure
  // ------------------------------------------------------------------
  localparam int DIV_W     = 5;
  localparam int MULT_W    = 5;
  localparam int ADDR_W    = 12;
  localparam int NUM_OUT   = 4;
  localparam int NUM_DIV   = NUM_OUT + 1;
  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 12'h100;
  localparam logic [ADDR_W-1:0] OFF_MULT   = 12'h110;
  localparam logic [ADDR_W-1:0] OFF_DIV0   = 12'h114;
  localparam logic [ADDR_W-1:0] OFF_DIV_ST = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_CMD    = 12'h138;
  localparam logic [ADDR_W-1:0] OFF_STAT   = 12'h13C;
  localparam logic [ADDR_W-1:0] OFF_ALIGN  = 12'h140;
  localparam logic [ADDR_W-1:0] OFF_BRIDGE = 12'h200;
  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int CTRL_ENGAGE_BIT  = 0;
  localparam int CTRL_RESET_BIT   = 1;
  localparam int CMD_APPLY_BIT    = 0;
  localparam int STAT_BUSY_BIT    = 0;
  localparam int STAT_LOCK_BIT    = 1;
  localparam int STAT_ENGAGED_BIT = 2;
  localparam int BRIDGE_RESET_BIT = 0;
  // ------------------------------------------------------------------
  // Reset values (divider fields hold ratio minus one)
  // ------------------------------------------------------------------
  localparam logic [MULT_W-1:0] MULT_RST   = 5'h0D;
  localparam logic [DIV_W-1:0]  PREDIV_RST = 5'h00;
  localparam logic [DIV_W-1:0]  CORE_RST   = 5'h00;
  localparam logic [DIV_W-1:0]  PERIPH_RST = 5'h01;
  localparam logic [DIV_W-1:0]  MEM_RST    = 5'h02;
  localparam logic [DIV_W-1:0]  AUX_RST    = 5'h00;
  localparam logic [1:0]        CTRL_RST   = 2'h0;
  localparam logic [NUM_OUT-1:0] ALIGN_RST = 4'h0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam real CLK_PERIOD_NS = 10.0;
  localparam real LOCK_TIME_US  = 187.5;
  localparam int  LOCK_CYCLES   = int'(LOCK_TIME_US * 1000.0 / CLK_PERIOD_NS);
  // ------------------------------------------------------------------
  // Bus channel states
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} wr_state_e;
  typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_DATA = 2'b10} rd_state_e;
endpackage : clk_ctrl_pkg
`default_nettype wire

// file: hw/divider_if.sv
// Control and tick signals between the controller and one divider stage
`default_nettype none
interface divider_if;
  logic                          src_tick;
  logic                          restart;
  logic                          apply;
  logic                          align;
  logic [clk_ctrl_pkg::DIV_W-1:0] ratio;
  logic                          tick;
  modport ctrl  (output src_tick, output restart, output apply, output align, output ratio,
                 input tick);
  modport stage (input src_tick, input restart, input apply, input align, input ratio,
                 output tick);
endinterface : divider_if
`default_nettype wire

// file: hw/clk_div_stage.sv
// One programmable divider stage producing a one-cycle clock enable
`default_nettype none
module clk_div_stage (
  input  wire logic core_clk_in,
  input  wire logic rst_n_in,
  input  wire logic [clk_ctrl_pkg::DIV_W-1:0] reset_ratio_in,
  divider_if.stage  bus
);
  logic [clk_ctrl_pkg::DIV_W-1:0] count_reg;
  logic [clk_ctrl_pkg::DIV_W-1:0] count_next;
  logic [clk_ctrl_pkg::DIV_W-1:0] ratio_reg;
  logic [clk_ctrl_pkg::DIV_W-1:0] ratio_next;
  logic                           tick_reg;
  logic                           tick_next;
  logic                           ratio_loaded_reg;
  logic                           ratio_loaded_next;

  always_comb begin
    count_next        = count_reg;
    ratio_next        = ratio_reg;
    tick_next         = 1'b0;
    ratio_loaded_next = 1'b1;
    if (!ratio_loaded_reg) begin
      ratio_next = reset_ratio_in;
    end else if (bus.restart) begin
      count_next = '0;
      ratio_next = bus.ratio;
    end else if (bus.apply) begin
      ratio_next = bus.ratio;
      if (bus.align) begin
        count_next = '0;
      end
    end else if (bus.src_tick) begin
      // Compare with >= so a shrunk ratio cannot leave the count stranded
      if (count_reg >= ratio_reg) begin
        tick_next  = 1'b1;
        count_next = '0;
      end else begin
        count_next = count_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_reg        <= '0;
      ratio_reg        <= '0;
      tick_reg         <= 1'b0;
      ratio_loaded_reg <= 1'b0;
    end else begin
      count_reg        <= count_next;
      ratio_reg        <= ratio_next;
      tick_reg         <= tick_next;
      ratio_loaded_reg <= ratio_loaded_next;
    end
  end

  assign bus.tick = tick_reg;
endmodule : clk_div_stage
`default_nettype wire

// file: hw/clock_gen_ctrl.sv
// Clock generator control: reference input, loop bypass, divider stages, AXI4-Lite registers
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`default_nettype none
module clock_gen_ctrl #(
  parameter int LOCK_CYCLES = clk_ctrl_pkg::LOCK_CYCLES
) (
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        osc_input_pin_in,
  input  wire logic        ext_clock_pin_in,
  input  wire logic [11:0] s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output var  logic        s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output var  logic        s_axi_wready_out,
  output var  logic [1:0]  s_axi_bresp_out,
  output var  logic        s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [11:0] s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output var  logic        s_axi_arready_out,
  output var  logic [31:0] s_axi_rdata_out,
  output var  logic [1:0]  s_axi_rresp_out,
  output var  logic        s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  output var  logic        core_clock_en_out,
  output var  logic        peripheral_clock_en_out,
  output var  logic        memory_port_clock_en_out,
  output var  logic        aux_clock_en_out,
  output var  logic        loop_reset_out,
  output var  logic        loop_engage_out,
  output var  logic        bridge_reset_out
);
  localparam int LCW = $clog2(LOCK_CYCLES + 1);
  localparam logic [LCW-1:0] LOCK_DONE = LCW'(LOCK_CYCLES);

  // ------------------------------------------------------------------
  // Reference pin synchronisers
  // ------------------------------------------------------------------
  logic [1:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
  logic       ref_prev_reg;
  logic       ref_level;
  logic       ref_tick;

  always_comb begin
    filt_next = (s2_reg & s3_reg) | (filt_reg & (s2_reg ^ s3_reg));
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_reg       <= 2'h0;
      s2_reg       <= 2'h0;
      s3_reg       <= 2'h0;
      filt_reg     <= 2'h0;
      ref_prev_reg <= 1'b0;
    end else begin
      s1_reg       <= {ext_clock_pin_in, osc_input_pin_in};
      s2_reg       <= s1_reg;
      s3_reg       <= s2_reg;
      filt_reg     <= filt_next;
      ref_prev_reg <= ref_level;
    end
  end

  // Both sources merge; a driven unused pin would corrupt the reference
  assign ref_level = |filt_reg;
  assign ref_tick  = ref_level & ~ref_prev_reg;

  // ------------------------------------------------------------------
  // Register state and bus channels
  // ------------------------------------------------------------------
  clk_ctrl_pkg::wr_state_e wr_state_reg, wr_state_next;
  clk_ctrl_pkg::rd_state_e rd_state_reg, rd_state_next;
  logic                           aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [11:0]                    aw_addr_reg, aw_addr_next;
  logic [31:0]                    w_data_reg, w_data_next;
  logic                           w_lane0_reg, w_lane0_next;
  logic [1:0]                     bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0]                    rdata_reg, rdata_next;
  logic                           awready_reg, awready_next, wready_reg, wready_next;
  logic                           arready_reg, arready_next;
  logic [1:0]                     ctrl_reg, ctrl_next;
  logic [clk_ctrl_pkg::MULT_W-1:0] mult_reg, mult_next;
  logic [clk_ctrl_pkg::DIV_W-1:0] div_reg [clk_ctrl_pkg::NUM_DIV];
  logic [clk_ctrl_pkg::DIV_W-1:0] div_next [clk_ctrl_pkg::NUM_DIV];
  logic [clk_ctrl_pkg::NUM_OUT-1:0] align_reg, align_next;
  logic                           bridge_reg, bridge_next;
  logic                           apply_pend_reg, apply_pend_next;
  logic                           engaged_reg, engaged_next;
  logic                           prediv_load_reg, prediv_load_next;
  logic [LCW-1:0]                 lock_cnt_reg, lock_cnt_next;
  logic                           lock_restart;
  logic                           sel_change;

  assign sel_change = engaged_reg != ctrl_reg[clk_ctrl_pkg::CTRL_ENGAGE_BIT];

  always_comb begin
    logic [11:0] wa;
    logic [11:0] ra;
    logic        hit;
    wa = aw_addr_reg;
    ra = s_axi_araddr_in;
    hit = 1'b0;
    wr_state_next    = wr_state_reg;
    rd_state_next    = rd_state_reg;
    aw_have_next     = aw_have_reg;
    w_have_next      = w_have_reg;
    aw_addr_next     = aw_addr_reg;
    w_data_next      = w_data_reg;
    w_lane0_next     = w_lane0_reg;
    bresp_next       = bresp_reg;
    rresp_next       = rresp_reg;
    rdata_next       = rdata_reg;
    ctrl_next        = ctrl_reg;
    mult_next        = mult_reg;
    div_next         = div_reg;
    align_next       = align_reg;
    bridge_next      = bridge_reg;
    prediv_load_next = 1'b0;
    lock_restart     = 1'b0;
    engaged_next     = ctrl_reg[clk_ctrl_pkg::CTRL_ENGAGE_BIT];
    // Set beats clear: a command written during the apply cycle is kept
    apply_pend_next  = 1'b0;
    if (s_axi_awvalid_in && awready_reg) begin
      aw_have_next = 1'b1;
      aw_addr_next = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && wready_reg) begin
      w_have_next  = 1'b1;
      w_data_next  = s_axi_wdata_in;
      w_lane0_next = s_axi_wstrb_in[0];
    end
    if (wr_state_reg == clk_ctrl_pkg::WR_IDLE && aw_have_reg && w_have_reg) begin
      aw_have_next  = 1'b0;
      w_have_next   = 1'b0;
      wr_state_next = clk_ctrl_pkg::WR_RESP;
      hit = 1'b1;
      case (wa[11:2])
        clk_ctrl_pkg::OFF_CTRL[11:2]: begin
          if (w_lane0_reg) ctrl_next = w_data_reg[1:0];
        end
        clk_ctrl_pkg::OFF_MULT[11:2]: begin
          if (w_lane0_reg) mult_next = w_data_reg[clk_ctrl_pkg::MULT_W-1:0];
          lock_restart = w_lane0_reg;
        end
        clk_ctrl_pkg::OFF_CMD[11:2]: begin
          if (w_lane0_reg && w_data_reg[clk_ctrl_pkg::CMD_APPLY_BIT]) begin
            apply_pend_next = 1'b1;
          end
        end
        clk_ctrl_pkg::OFF_STAT[11:2]: ;
        clk_ctrl_pkg::OFF_ALIGN[11:2]: begin
          if (w_lane0_reg) align_next = w_data_reg[clk_ctrl_pkg::NUM_OUT-1:0];
        end
        clk_ctrl_pkg::OFF_BRIDGE[11:2]: begin
          if (w_lane0_reg) bridge_next = w_data_reg[clk_ctrl_pkg::BRIDGE_RESET_BIT];
        end
        default: hit = 1'b0;
      endcase
      for (int i = 0; i < clk_ctrl_pkg::NUM_DIV; i++) begin
        if (wa == 12'(clk_ctrl_pkg::OFF_DIV0 + 12'(i) * clk_ctrl_pkg::OFF_DIV_ST)) begin
          hit = 1'b1;
          if (w_lane0_reg) div_next[i] = w_data_reg[clk_ctrl_pkg::DIV_W-1:0];
          if (i == 0) begin
            prediv_load_next = w_lane0_reg;
            lock_restart     = w_lane0_reg;
          end
        end
      end
      bresp_next = hit ? clk_ctrl_pkg::RESP_OKAY : clk_ctrl_pkg::RESP_SLVERR;
    end else if (wr_state_reg == clk_ctrl_pkg::WR_RESP && s_axi_bready_in) begin
      wr_state_next = clk_ctrl_pkg::WR_IDLE;
    end
    apply_pend_next = apply_pend_next | (apply_pend_reg & 1'b0);
    if (rd_state_reg == clk_ctrl_pkg::RD_IDLE && s_axi_arvalid_in && arready_reg) begin
      rd_state_next = clk_ctrl_pkg::RD_DATA;
      rdata_next    = 32'h0000_0000;
      rresp_next    = clk_ctrl_pkg::RESP_OKAY;
      case (ra[11:2])
        clk_ctrl_pkg::OFF_CTRL[11:2]:   rdata_next[1:0] = ctrl_reg;
        clk_ctrl_pkg::OFF_MULT[11:2]:   rdata_next[clk_ctrl_pkg::MULT_W-1:0] = mult_reg;
        clk_ctrl_pkg::OFF_CMD[11:2]:    ;
        clk_ctrl_pkg::OFF_STAT[11:2]: begin
          rdata_next[clk_ctrl_pkg::STAT_BUSY_BIT]    = apply_pend_reg;
          rdata_next[clk_ctrl_pkg::STAT_LOCK_BIT]    = lock_cnt_reg == LOCK_DONE;
          rdata_next[clk_ctrl_pkg::STAT_ENGAGED_BIT] = engaged_reg;
        end
        clk_ctrl_pkg::OFF_ALIGN[11:2]:  rdata_next[clk_ctrl_pkg::NUM_OUT-1:0] = align_reg;
        clk_ctrl_pkg::OFF_BRIDGE[11:2]: rdata_next[0] = bridge_reg;
        default:                        rresp_next = clk_ctrl_pkg::RESP_SLVERR;
      endcase
      for (int i = 0; i < clk_ctrl_pkg::NUM_DIV; i++) begin
        if (ra == 12'(clk_ctrl_pkg::OFF_DIV0 + 12'(i) * clk_ctrl_pkg::OFF_DIV_ST)) begin
          rdata_next[clk_ctrl_pkg::DIV_W-1:0] = div_reg[i];
          rresp_next = clk_ctrl_pkg::RESP_OKAY;
        end
      end
    end else if (rd_state_reg == clk_ctrl_pkg::RD_DATA && s_axi_rready_in) begin
      rd_state_next = clk_ctrl_pkg::RD_IDLE;
    end
    awready_next = !aw_have_next;
    wready_next  = !w_have_next;
    arready_next = rd_state_next == clk_ctrl_pkg::RD_IDLE;
    // Lock timer; loop reset and multiplier or predivider writes start it over
    if (lock_restart || ctrl_next[clk_ctrl_pkg::CTRL_RESET_BIT]) begin
      lock_cnt_next = '0;
    end else if (lock_cnt_reg != LOCK_DONE) begin
      lock_cnt_next = lock_cnt_reg + 1'b1;
    end else begin
      lock_cnt_next = lock_cnt_reg;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_state_reg    <= clk_ctrl_pkg::WR_IDLE;
      rd_state_reg    <= clk_ctrl_pkg::RD_IDLE;
      aw_have_reg     <= 1'b0;
      w_have_reg      <= 1'b0;
      aw_addr_reg     <= 12'h000;
      w_data_reg      <= 32'h0000_0000;
      w_lane0_reg     <= 1'b0;
      bresp_reg       <= clk_ctrl_pkg::RESP_OKAY;
      rresp_reg       <= clk_ctrl_pkg::RESP_OKAY;
      rdata_reg       <= 32'h0000_0000;
      awready_reg     <= 1'b0;
      wready_reg      <= 1'b0;
      arready_reg     <= 1'b0;
      ctrl_reg        <= clk_ctrl_pkg::CTRL_RST;
      mult_reg        <= clk_ctrl_pkg::MULT_RST;
      div_reg[0]      <= clk_ctrl_pkg::PREDIV_RST;
      div_reg[1]      <= clk_ctrl_pkg::CORE_RST;
      div_reg[2]      <= clk_ctrl_pkg::PERIPH_RST;
      div_reg[3]      <= clk_ctrl_pkg::MEM_RST;
      div_reg[4]      <= clk_ctrl_pkg::AUX_RST;
      align_reg       <= clk_ctrl_pkg::ALIGN_RST;
      bridge_reg      <= 1'b0;
      apply_pend_reg  <= 1'b0;
      engaged_reg     <= 1'b0;
      prediv_load_reg <= 1'b0;
      lock_cnt_reg    <= '0;
    end else begin
      wr_state_reg    <= wr_state_next;
      rd_state_reg    <= rd_state_next;
      aw_have_reg     <= aw_have_next;
      w_have_reg      <= w_have_next;
      aw_addr_reg     <= aw_addr_next;
      w_data_reg      <= w_data_next;
      w_lane0_reg     <= w_lane0_next;
      bresp_reg       <= bresp_next;
      rresp_reg       <= rresp_next;
      rdata_reg       <= rdata_next;
      awready_reg     <= awready_next;
      wready_reg      <= wready_next;
      arready_reg     <= arready_next;
      ctrl_reg        <= ctrl_next;
      mult_reg        <= mult_next;
      div_reg         <= div_next;
      align_reg       <= align_next;
      bridge_reg      <= bridge_next;
      apply_pend_reg  <= apply_pend_next;
      engaged_reg     <= engaged_next;
      prediv_load_reg <= prediv_load_next;
      lock_cnt_reg    <= lock_cnt_next;
    end
  end

  // ------------------------------------------------------------------
  // Divider stages: predivider plus four output stages
  // ------------------------------------------------------------------
  divider_if div_bus [clk_ctrl_pkg::NUM_DIV] ();
  logic [clk_ctrl_pkg::DIV_W-1:0] div_rst [clk_ctrl_pkg::NUM_DIV];
  logic [clk_ctrl_pkg::NUM_OUT-1:0] out_en_reg, out_en_next;

  assign div_rst[0] = clk_ctrl_pkg::PREDIV_RST;
  assign div_rst[1] = clk_ctrl_pkg::CORE_RST;
  assign div_rst[2] = clk_ctrl_pkg::PERIPH_RST;
  assign div_rst[3] = clk_ctrl_pkg::MEM_RST;
  assign div_rst[4] = clk_ctrl_pkg::AUX_RST;

  // Predivider takes a new value at once; the loop then relocks
  assign div_bus[0].src_tick = ref_tick;
  assign div_bus[0].restart  = prediv_load_reg;
  assign div_bus[0].apply    = 1'b0;
  assign div_bus[0].align    = 1'b0;
  assign div_bus[0].ratio    = div_reg[0];

  for (genvar g = 0; g < clk_ctrl_pkg::NUM_DIV; g++) begin : g_stage
    clk_div_stage u_stage (
      .core_clk_in    (core_clk_in),
      .rst_n_in       (rst_n_in),
      .reset_ratio_in (div_rst[g]),
      .bus            (div_bus[g])
    );
    if (g > 0) begin : g_out
      // Loop output is the core clock; bypass runs on raw reference edges
      assign div_bus[g].src_tick = engaged_reg ? 1'b1 : ref_tick;
      // Source swap restarts every output stage together so no short pulse escapes
      assign div_bus[g].restart  = sel_change;
      assign div_bus[g].apply    = apply_pend_reg;
      assign div_bus[g].align    = align_reg[g-1];
      assign div_bus[g].ratio    = div_reg[g];
      assign out_en_next[g-1]    = div_bus[g].tick;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_en_reg <= '0;
    end else begin
      out_en_reg <= out_en_next;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign s_axi_awready_out        = awready_reg;
  assign s_axi_wready_out         = wready_reg;
  assign s_axi_bvalid_out         = wr_state_reg == clk_ctrl_pkg::WR_RESP;
  assign s_axi_bresp_out          = bresp_reg;
  assign s_axi_arready_out        = arready_reg;
  assign s_axi_rvalid_out         = rd_state_reg == clk_ctrl_pkg::RD_DATA;
  assign s_axi_rdata_out          = rdata_reg;
  assign s_axi_rresp_out          = rresp_reg;
  assign core_clock_en_out        = out_en_reg[0];
  assign peripheral_clock_en_out  = out_en_reg[1];
  assign memory_port_clock_en_out = out_en_reg[2];
  assign aux_clock_en_out         = out_en_reg[3];
  assign loop_reset_out           = ctrl_reg[clk_ctrl_pkg::CTRL_RESET_BIT];
  assign loop_engage_out          = engaged_reg;
  // Bridge reset is a plain register; software sequences it around changes
  assign bridge_reset_out         = bridge_reg;
endmodule : clock_gen_ctrl
`default_nettype wire

// file: bench/clock_gen_ctrl_asserts.sv
// Port-level assertions for the clock generator control block
`default_nettype none
module clock_gen_ctrl_asserts (
  input wire logic        core_clk_in,
  input wire logic        rst_n_in,
  input wire logic        osc_input_pin_in,
  input wire logic        ext_clock_pin_in,
  input wire logic [11:0] s_axi_awaddr_in,
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0]  s_axi_wstrb_in,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        core_clock_en_out,
  input wire logic        loop_engage_out,
  input wire logic        bridge_reset_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  wire logic wt = s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
  sequence wr_take(a);
    wt && s_axi_awaddr_in == a && s_axi_wstrb_in[0];
  endsequence
  // Register plus output stage: new level seen three edges after the take
  property follows(a, o);
    wr_take(a) |-> ##3 o == $past(s_axi_wdata_in[0], 3);
  endproperty
  wr_answer_a: assert property (wt |-> ##[1:2] s_axi_bvalid_out) else $error("no write response");
  b_single_a: assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out)
    else $error("write response repeated");
  rd_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("no read data");
  ar_blocked_a: assert property (s_axi_rvalid_out |-> !s_axi_arready_out) else $error("ar open");
  engage_off_a: assert property ($rose(rst_n_in) |-> !loop_engage_out)
    else $error("loop engaged out of reset");
  engage_follow_a: assert property (follows(clk_ctrl_pkg::OFF_CTRL, loop_engage_out))
    else $error("engage not following write");
  bridge_follow_a: assert property (follows(clk_ctrl_pkg::OFF_BRIDGE, bridge_reset_out))
    else $error("bridge reset not following write");
  bypass_quiet_a: assert property (
    (!loop_engage_out && !osc_input_pin_in && !ext_clock_pin_in)[*8] |-> !core_clock_en_out)
    else $error("core tick without reference");
endmodule : clock_gen_ctrl_asserts
bind clock_gen_ctrl clock_gen_ctrl_asserts i_clock_gen_ctrl_asserts (.*);
`default_nettype wire

// file: bench/ref_clock_source.sv
// Reference source model: crystal oscillator or external clock pin
`default_nettype none
module ref_clock_source (
  input  wire logic run_in,
  input  wire logic use_ext_in,
  output wire logic osc_out,
  output wire logic ext_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ph = 1'b0;
  // 25 MHz keeps the loop reference inside its window; stopped source rests low
  always #20 ph = run_in ? ~ph : 1'b0;
  assign osc_out = ph & ~use_ext_in; // Unused input held low
  assign ext_out = ph & use_ext_in;
endmodule : ref_clock_source
`default_nettype wire

// file: bench/pll_clock_generator_control_tb.sv
// Self-checking bench for the clock generator control block
`default_nettype none
module pll_clock_generator_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in = 0, rst_n_in = 0, run = 0, use_ext = 0, s_axi_awvalid_in = 0;
  logic s_axi_wvalid_in = 0, s_axi_bready_in = 0, s_axi_arvalid_in = 0, s_axi_rready_in = 0;
  logic [11:0] s_axi_awaddr_in = '0, s_axi_araddr_in = '0;
  logic [31:0] s_axi_wdata_in = '0, s_axi_rdata_out;
  logic [3:0]  s_axi_wstrb_in = 4'hF;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
  logic osc_input_pin_in, ext_clock_pin_in, s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  logic s_axi_arready_out, s_axi_rvalid_out, loop_reset_out, loop_engage_out, bridge_reset_out;
  logic core_clock_en_out, peripheral_clock_en_out, memory_port_clock_en_out, aux_clock_en_out;
  wire logic [3:0] en = {aux_clock_en_out, memory_port_clock_en_out, peripheral_clock_en_out,
                         core_clock_en_out};
  int error_cnt = 0, total_checks = 0, app = 1, mdl[int];
  logic [15:0] lfsr = 16'h5602;
  clock_gen_ctrl #(.LOCK_CYCLES(20)) i_clock_gen_ctrl (.*);
  ref_clock_source i_ref_clock_source (.run_in(run), .use_ext_in(use_ext),
    .osc_out(osc_input_pin_in), .ext_out(ext_clock_pin_in));
  initial forever #5 core_clk_in = ~core_clk_in;
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [15:0] lfsr_step(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_step
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic wr(logic [11:0] a, logic [31:0] d, logic [1:0] er);
    @(posedge core_clk_in);
    {s_axi_awaddr_in, s_axi_wdata_in} <= {a, d};
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'h7;
    forever begin
      @(posedge core_clk_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 0;
      if (s_axi_bvalid_out) break;
    end
    s_axi_bready_in <= 0;
    chk(s_axi_bresp_out, er);
  endtask : wr
  task automatic rd(logic [11:0] a, logic [31:0] e, logic [1:0] er);
    @(posedge core_clk_in);
    {s_axi_araddr_in, s_axi_arvalid_in, s_axi_rready_in} <= {a, 2'h3};
    forever begin
      @(posedge core_clk_in);
      if (s_axi_arready_out) s_axi_arvalid_in <= 0;
      if (s_axi_rvalid_out) break;
    end
    s_axi_rready_in <= 0;
    chk(s_axi_rdata_out, e);
    chk(s_axi_rresp_out, er);
  endtask : rd
  task automatic wm(logic [11:0] a, logic [31:0] d);
    wr(a, d, 2'h0);
    mdl[a] = d;
    rd(a, d, 2'h0);
  endtask : wm
  // Cycles between two consecutive enables of one stage
  task automatic gap(int i, int e);
    int n = 0;
    do @(posedge core_clk_in); while (en[i] !== 1'b1);
    do begin @(posedge core_clk_in); n++; end while (en[i] !== 1'b1 && n < 99);
    chk(n, e);
  endtask : gap
  initial begin
    mdl = '{12'h100:0, 12'h110:13, 12'h114:0, 12'h118:0, 12'h11C:1, 12'h120:2, 12'h124:0,
            12'h138:0, 12'h140:0, 12'h200:0};
    repeat (16) @(posedge core_clk_in);
    rst_n_in <= 1;
    repeat (2) @(posedge core_clk_in);
    foreach (mdl[a]) rd(a[11:0], mdl[a], 2'h0);
    rd(12'hFF0, 0, 2'h2);
    wr(12'hFF0, 32'hFFFF_FFFF, 2'h2);
    run <= 1;
    for (int x = 0; x < 2; x++) begin
      use_ext <= x[0];
      repeat (8) @(posedge core_clk_in);
      gap(0, 4);
      gap(1, 8);
    end
    run <= 0;
    repeat (12) @(posedge core_clk_in);
    $display("test bypass done");
    wm(12'h100, 1);
    chk(loop_engage_out, 1);
    gap(0, 1);
    gap(1, 2);
    gap(2, 3);
    gap(3, 1);
    wm(12'h140, 7);
    for (int k = 0; k < 3; k++) begin
      lfsr = lfsr_step(lfsr);
      wm(12'h110, 32'(6 + lfsr % 19));
      wm(12'h118, 32'(lfsr[1:0]));
      wm(12'h11C, 32'(2 * lfsr[1:0] + 1));
      repeat (40) @(posedge core_clk_in);
      gap(0, app);
      wr(12'h138, 1, 2'h0);
      app = lfsr[1:0] + 1;
      repeat (40) @(posedge core_clk_in);
      gap(0, app);
      gap(1, 2 * app);
      chk(en[0], 1);
    end
    $display("test divider apply done");
    wm(12'h110, 24);
    rd(12'h13C, 4, 2'h0);
    repeat (30) @(posedge core_clk_in);
    rd(12'h13C, 6, 2'h0);
    wm(12'h100, 3);
    chk(loop_reset_out, 1);
    repeat (30) @(posedge core_clk_in);
    rd(12'h13C, 4, 2'h0);
    wm(12'h100, 1);
    s_axi_wstrb_in <= 4'h0;
    wr(12'h200, 1, 2'h0);
    s_axi_wstrb_in <= 4'hF;
    rd(12'h200, 0, 2'h0);
    wm(12'h200, 1);
    chk(bridge_reset_out, 1);
    wm(12'h200, 0);
    $display("test lock bridge align done");
    test_done();
  end
  initial begin
    repeat (20000) @(posedge core_clk_in);
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done();
  end
endmodule : pll_clock_generator_control_tb
`default_nettype wire
